// ---- rtl/mbac_top.sv ----
// mode based access control: apb registers, register permission and memory checks
`timescale 1ns/100ps
`include "mbac_defines.svh"
// Overview of operation
// - reset loads fixed default security attributes into all control registers.
// - after reset every memory segment is disabled until privileged software enables.
// - vendor code partition boundary is a hardware constant, never writable.
// - segment table pointer changes only on privileged mode writes.
// - memory management registers are read and written only in privileged mode.
// - hardware unit registers are reachable in privileged mode.
// - unprivileged mode reaches only registers needed to run the cpu by default.
// - unit registers open to unprivileged mode only when explicitly granted.
// - register access attributes fixed except unit grants for user and vendor modes.
// - every register resets to a defined value and defined permission.
module mbac_top (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [1:0] cpu_mode_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`MBAC_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic mem_write_i,
    output logic mem_ack_o,
    output logic mem_grant_o,
    output logic mem_viol_o,
    output logic sfr_viol_o,
    output logic irq_o,
    output logic [31:0] seg_table_ptr_o,
    output logic [`MBAC_NUM_SEG-1:0] seg_enable_o,
    output logic [32*`MBAC_NUM_HWU-1:0] hwu_ctrl_o
);
    logic [31:0] seg_ptr_ff;
    logic [`MBAC_NUM_SEG-1:0] seg_en_ff;
    logic [`MBAC_NUM_SEG-1:0] seg_wr_ff;
    logic [`MBAC_NUM_HWU-1:0] usr_grant_ff;
    logic [`MBAC_NUM_HWU-1:0] vnd_grant_ff;
    logic [1:0] int_stat_ff;
    logic [1:0] int_mask_ff;
    logic [1:0] nxt_int_stat;
    logic [31:0] viol_addr_ff;
    logic [31:0] hwu_ff [`MBAC_NUM_HWU];
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic sfr_viol_ff;
    logic irq_ff;
    logic acc_ok_ff;
    logic mapped;
    logic allowed;
    logic setup;
    logic done;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_val;
    logic mem_ack;
    logic mem_grant;
    logic mem_viol;

    assign setup = psel_i && !penable_i;
    assign done = psel_i && penable_i && pready_ff;
    assign wr_ok = done && pwrite_i && acc_ok_ff;
    assign rd_ok = setup && !pwrite_i && mapped && allowed;

    mbac_sfr_perm u_perm (
        .addr_i(paddr_i),
        .mode_i(cpu_mode_i),
        .usr_grant_i(usr_grant_ff),
        .vnd_grant_i(vnd_grant_ff),
        .mapped_o(mapped),
        .allowed_o(allowed)
    );

    mbac_mem_check u_mem (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .req_i(mem_req_i),
        .addr_i(mem_addr_i),
        .write_i(mem_write_i),
        .mode_i(cpu_mode_i),
        .seg_en_i(seg_en_ff),
        .seg_wr_i(seg_wr_ff),
        .ack_o(mem_ack),
        .grant_o(mem_grant),
        .viol_o(mem_viol)
    );

    // apb handshake: decision taken in setup, transfer ends in first access cycle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            acc_ok_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !(mapped && allowed);
            acc_ok_ff <= setup && mapped && allowed;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (paddr_i)
            `MBAC_OFS_SEG_PTR: rd_val = seg_ptr_ff;
            `MBAC_OFS_SEG_EN: rd_val = {24'h00_0000, seg_en_ff};
            `MBAC_OFS_SEG_WR: rd_val = {24'h00_0000, seg_wr_ff};
            `MBAC_OFS_USR_GRANT: rd_val = {28'h000_0000, usr_grant_ff};
            `MBAC_OFS_VND_GRANT: rd_val = {28'h000_0000, vnd_grant_ff};
            `MBAC_OFS_INT_STAT: rd_val = {30'h0000_0000, int_stat_ff};
            `MBAC_OFS_INT_MASK: rd_val = {30'h0000_0000, int_mask_ff};
            `MBAC_OFS_VIOL_ADDR: rd_val = viol_addr_ff;
            `MBAC_OFS_PART_BOUND: rd_val = `MBAC_PART_BOUND;
            `MBAC_OFS_CPU_STAT: rd_val = {30'h0000_0000, cpu_mode_i};
            default: begin
                if (mapped) begin
                    rd_val = hwu_ff[paddr_i[`MBAC_HWU_IDX_MSB:`MBAC_HWU_IDX_LSB]];
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_ok) begin
            prdata_ff <= rd_val;
        end else if (setup) begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seg_ptr_ff <= `MBAC_RST_SEG_PTR;
            seg_en_ff <= `MBAC_RST_SEG_EN;
            seg_wr_ff <= `MBAC_RST_SEG_WR;
        end else if (wr_ok) begin
            if (paddr_i == `MBAC_OFS_SEG_PTR) begin
                seg_ptr_ff <= pwdata_i;
            end
            if (paddr_i == `MBAC_OFS_SEG_EN) begin
                seg_en_ff <= pwdata_i[`MBAC_NUM_SEG-1:0];
            end
            if (paddr_i == `MBAC_OFS_SEG_WR) begin
                seg_wr_ff <= pwdata_i[`MBAC_NUM_SEG-1:0];
            end
        end
    end

    // only the unit grants are configurable
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            usr_grant_ff <= `MBAC_RST_GRANT;
            vnd_grant_ff <= `MBAC_RST_GRANT;
        end else if (wr_ok) begin
            if (paddr_i == `MBAC_OFS_USR_GRANT) begin
                usr_grant_ff <= pwdata_i[`MBAC_NUM_HWU-1:0];
            end
            if (paddr_i == `MBAC_OFS_VND_GRANT) begin
                vnd_grant_ff <= pwdata_i[`MBAC_NUM_HWU-1:0];
            end
        end
    end

    // hardware unit control words
    genvar gi;
    generate
        for (gi = 0; gi < `MBAC_NUM_HWU; gi++) begin : g_hwu
            localparam logic [`MBAC_ADDR_W-1:0] OFS = `MBAC_OFS_HWU_BASE + 12'(4 * gi);
            always_ff @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    hwu_ff[gi] <= `MBAC_RST_HWU;
                end else if (wr_ok && paddr_i == OFS) begin
                    hwu_ff[gi] <= pwdata_i;
                end
            end
            assign hwu_ctrl_o[32*gi+31:32*gi] = hwu_ff[gi];
        end
    endgenerate

    // sticky violation status, set wins over write-one clear
    always_comb begin
        nxt_int_stat = int_stat_ff;
        if (wr_ok && paddr_i == `MBAC_OFS_INT_STAT) begin
            nxt_int_stat = int_stat_ff & ~pwdata_i[1:0];
        end
        if (mem_viol) begin
            nxt_int_stat[`MBAC_INT_MEM_BIT] = 1'b1;
        end
        if (done && !acc_ok_ff) begin
            nxt_int_stat[`MBAC_INT_SFR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_stat_ff <= `MBAC_RST_INT;
            int_mask_ff <= `MBAC_RST_INT;
            irq_ff <= 1'b0;
        end else begin
            int_stat_ff <= nxt_int_stat;
            if (wr_ok && paddr_i == `MBAC_OFS_INT_MASK) begin
                int_mask_ff <= pwdata_i[1:0];
            end
            irq_ff <= |(int_stat_ff & int_mask_ff);
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sfr_viol_ff <= 1'b0;
            viol_addr_ff <= 32'h0000_0000;
        end else begin
            sfr_viol_ff <= done && !acc_ok_ff;
            if (done && !acc_ok_ff) begin
                viol_addr_ff <= {20'h0_0000, paddr_i};
            end else if (setup && mem_req_i) begin
                viol_addr_ff <= viol_addr_ff;
            end
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign mem_ack_o = mem_ack;
    assign mem_grant_o = mem_grant;
    assign mem_viol_o = mem_viol;
    assign sfr_viol_o = sfr_viol_ff;
    assign irq_o = irq_ff;
    assign seg_table_ptr_o = seg_ptr_ff;
    assign seg_enable_o = seg_en_ff;
endmodule // mbac_top

// ---- rtl/mbac_defines.svh ----
// offsets, field positions, reset values and fixed limits of the access control block
`ifndef MBAC_DEFINES_SVH
`define MBAC_DEFINES_SVH

`define MBAC_ADDR_W 12
`define MBAC_OFS_SEG_PTR 12'h000
`define MBAC_OFS_SEG_EN 12'h004
`define MBAC_OFS_SEG_WR 12'h008
`define MBAC_OFS_USR_GRANT 12'h00C
`define MBAC_OFS_VND_GRANT 12'h010
`define MBAC_OFS_INT_STAT 12'h014
`define MBAC_OFS_INT_MASK 12'h018
`define MBAC_OFS_VIOL_ADDR 12'h01C
`define MBAC_OFS_PART_BOUND 12'h020
`define MBAC_OFS_CPU_STAT 12'h024
`define MBAC_OFS_HWU_BASE 12'h040

`define MBAC_NUM_SEG 8
`define MBAC_NUM_HWU 4
`define MBAC_HWU_IDX_MSB 3
`define MBAC_HWU_IDX_LSB 2
`define MBAC_SEG_IDX_MSB 18
`define MBAC_SEG_IDX_LSB 16

`define MBAC_PART_BOUND 32'h0001_0000

`define MBAC_RST_SEG_PTR 32'h0000_0000
`define MBAC_RST_SEG_EN 8'h00
`define MBAC_RST_SEG_WR 8'h00
`define MBAC_RST_GRANT 4'h0
`define MBAC_RST_INT 2'h0
`define MBAC_RST_HWU 32'h0000_0000

`define MBAC_INT_MEM_BIT 0
`define MBAC_INT_SFR_BIT 1

`endif

// ---- rtl/mbac_pkg.sv ----
// types shared by the access control block
package mbac_pkg;
    typedef enum logic [1:0] {
        mbac_mode_priv,
        mbac_mode_user,
        mbac_mode_vendor
    } mbac_mode_t;

    typedef enum logic [1:0] {
        mbac_cls_none,
        mbac_cls_cpu,
        mbac_cls_mmu,
        mbac_cls_hwu
    } mbac_cls_t;
endpackage

// ---- rtl/mbac_sfr_perm.sv ----
// register class decode and mode based register permission
`timescale 1ns/100ps
`include "mbac_defines.svh"
module mbac_sfr_perm (
    input wire logic [`MBAC_ADDR_W-1:0] addr_i,
    input wire logic [1:0] mode_i,
    input wire logic [`MBAC_NUM_HWU-1:0] usr_grant_i,
    input wire logic [`MBAC_NUM_HWU-1:0] vnd_grant_i,
    output logic mapped_o,
    output logic allowed_o
);
    function automatic mbac_pkg::mbac_cls_t cls_of(input logic [`MBAC_ADDR_W-1:0] a);
        mbac_pkg::mbac_cls_t c;
        c = mbac_pkg::mbac_cls_none;
        if (a == `MBAC_OFS_CPU_STAT) begin
            c = mbac_pkg::mbac_cls_cpu;
        end else if (a == `MBAC_OFS_SEG_PTR || a == `MBAC_OFS_SEG_EN || a == `MBAC_OFS_SEG_WR ||
                     a == `MBAC_OFS_USR_GRANT || a == `MBAC_OFS_VND_GRANT ||
                     a == `MBAC_OFS_INT_STAT || a == `MBAC_OFS_INT_MASK ||
                     a == `MBAC_OFS_VIOL_ADDR || a == `MBAC_OFS_PART_BOUND) begin
            c = mbac_pkg::mbac_cls_mmu;
        end else if (a[`MBAC_ADDR_W-1:`MBAC_HWU_IDX_MSB+1] ==
                     `MBAC_OFS_HWU_BASE >> (`MBAC_HWU_IDX_MSB+1) && a[1:0] == 2'h0) begin
            c = mbac_pkg::mbac_cls_hwu;
        end
        return c;
    endfunction

    mbac_pkg::mbac_cls_t cls;
    mbac_pkg::mbac_mode_t mode;
    logic [1:0] unit;

    assign cls = cls_of(addr_i);
    assign mode = mbac_pkg::mbac_mode_t'(mode_i);
    assign unit = addr_i[`MBAC_HWU_IDX_MSB:`MBAC_HWU_IDX_LSB];
    assign mapped_o = (cls != mbac_pkg::mbac_cls_none);

    always_comb begin
        allowed_o = 1'b0;
        unique case (mode)
            mbac_pkg::mbac_mode_priv: allowed_o = mapped_o;
            mbac_pkg::mbac_mode_user: begin
                allowed_o = (cls == mbac_pkg::mbac_cls_cpu) ||
                            (cls == mbac_pkg::mbac_cls_hwu && usr_grant_i[unit]);
            end
            mbac_pkg::mbac_mode_vendor: begin
                allowed_o = (cls == mbac_pkg::mbac_cls_cpu) ||
                            (cls == mbac_pkg::mbac_cls_hwu && vnd_grant_i[unit]);
            end
            default: allowed_o = 1'b0;
        endcase
    end
endmodule // mbac_sfr_perm

// ---- rtl/mbac_mem_check.sv ----
// partition and segmentation check on core memory requests
`timescale 1ns/100ps
`include "mbac_defines.svh"
module mbac_mem_check (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic write_i,
    input wire logic [1:0] mode_i,
    input wire logic [`MBAC_NUM_SEG-1:0] seg_en_i,
    input wire logic [`MBAC_NUM_SEG-1:0] seg_wr_i,
    output logic ack_o,
    output logic grant_o,
    output logic viol_o
);
    mbac_pkg::mbac_mode_t mode;
    logic [2:0] seg;
    logic vendor_area;
    logic ok;
    logic ack_ff;
    logic grant_ff;
    logic viol_ff;

    assign mode = mbac_pkg::mbac_mode_t'(mode_i);
    assign seg = addr_i[`MBAC_SEG_IDX_MSB:`MBAC_SEG_IDX_LSB];
    assign vendor_area = (addr_i < `MBAC_PART_BOUND);

    always_comb begin
        ok = 1'b0;
        if (vendor_area) begin
            ok = (mode == mbac_pkg::mbac_mode_vendor);
        end else begin
            unique case (mode)
                mbac_pkg::mbac_mode_priv: ok = 1'b1;
                mbac_pkg::mbac_mode_user,
                mbac_pkg::mbac_mode_vendor: ok = seg_en_i[seg] && (!write_i || seg_wr_i[seg]);
                default: ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_ff <= 1'b0;
            grant_ff <= 1'b0;
            viol_ff <= 1'b0;
        end else begin
            ack_ff <= req_i;
            grant_ff <= req_i && ok;
            viol_ff <= req_i && !ok;
        end
    end

    assign ack_o = ack_ff;
    assign grant_o = grant_ff;
    assign viol_o = viol_ff;
endmodule // mbac_mem_check

// ---- rtl/mbac_unused_guard.sv ----
`timescale 1ns/100ps

// ---- tb/mbac_chk_asserts.sv ----
// port assertions for the access control block
`timescale 1ns/100ps
`include "mbac_defines.svh"
module mbac_chk (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [1:0] cpu_mode_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [`MBAC_ADDR_W-1:0] paddr_i,
    input wire logic pslverr_o,
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic mem_ack_o,
    input wire logic mem_grant_o,
    input wire logic mem_viol_o,
    input wire logic sfr_viol_o,
    input wire logic [31:0] seg_table_ptr_o,
    input wire logic [`MBAC_NUM_SEG-1:0] seg_enable_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    a_seg_reset_off: assert property ($rose(rstn_i) |-> seg_enable_o == 8'h00)
        else $error("segments open after reset");
    a_ack_after_req: assert property (mem_req_i |=> mem_ack_o)
        else $error("memory request not answered");
    a_one_verdict: assert property (mem_ack_o |-> mem_grant_o != mem_viol_o)
        else $error("memory answer without single verdict");
    a_no_spur_ack: assert property (!mem_req_i |=> !mem_ack_o && !mem_grant_o)
        else $error("memory answer without request");
    a_part_fixed: assert property (mem_req_i && mem_addr_i < `MBAC_PART_BOUND
        && cpu_mode_i != 2'h2 |=> mem_viol_o)
        else $error("vendor partition reached outside vendor mode");
    a_user_seg_closed: assert property (mem_req_i && cpu_mode_i == 2'h1
        && mem_addr_i >= `MBAC_PART_BOUND && !seg_enable_o[mem_addr_i[18:16]] |=> mem_viol_o)
        else $error("disabled segment granted");
    a_ptr_priv_only: assert property (psel_i && !penable_i && cpu_mode_i != 2'h0
        |=> ##1 $stable(seg_table_ptr_o) && $stable(seg_enable_o))
        else $error("segment setup changed outside privileged mode");
    a_mmu_priv_only: assert property (psel_i && !penable_i && cpu_mode_i != 2'h0
        && paddr_i < `MBAC_OFS_CPU_STAT |=> pslverr_o)
        else $error("mmu register open outside privileged mode");
    a_cpu_stat_open: assert property (psel_i && !penable_i && cpu_mode_i != 2'h3
        && paddr_i == `MBAC_OFS_CPU_STAT |=> !pslverr_o)
        else $error("cpu status register refused");
    a_err_viol_pulse: assert property (pslverr_o |=> sfr_viol_o)
        else $error("refused transfer without violation pulse");
endmodule // mbac_chk

bind mbac_top mbac_chk u_chk (.mclk_i, .rstn_i, .cpu_mode_i, .psel_i, .penable_i, .paddr_i,
    .pslverr_o, .mem_req_i, .mem_addr_i, .mem_ack_o, .mem_grant_o, .mem_viol_o, .sfr_viol_o,
    .seg_table_ptr_o, .seg_enable_o);

// ---- tb/mbac_core_model.sv ----
// processor core model: holds the cpu mode and issues memory requests
`timescale 1ns/100ps
module mbac_core_model (
    input wire logic mclk_i,
    input wire logic mem_ack_i,
    input wire logic mem_grant_i,
    input wire logic mem_viol_i,
    output logic [1:0] cpu_mode_o,
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    output logic mem_write_o
);
    initial begin
        cpu_mode_o = 2'h0;
        mem_req_o = 1'b0;
        mem_addr_o = 32'h0;
        mem_write_o = 1'b0;
    end
    task automatic set_mode(input logic [1:0] m);
        @(posedge mclk_i);
        cpu_mode_o <= m;
    endtask
    task automatic access(input logic [31:0] a, input logic wr, output logic ok, output logic bad);
        @(posedge mclk_i);
        mem_req_o <= 1'b1;
        mem_addr_o <= a;
        mem_write_o <= wr;
        @(posedge mclk_i);
        mem_req_o <= 1'b0;
        // released address must not keep its last value
        mem_addr_o <= ~a;
        mem_write_o <= ~wr;
        do begin
            @(posedge mclk_i);
        end while (mem_ack_i !== 1'b1);
        ok = mem_grant_i;
        bad = mem_viol_i;
    endtask
endmodule // mbac_core_model

// ---- tb/tb.sv ----
// self-checking bench for the access control block
`timescale 1ns/100ps
`include "mbac_defines.svh"
module tb;
    logic mclk_i, rstn_i, psel, penable, pwrite, pready, pslverr;
    logic mem_req, mem_write, mem_ack, mem_grant, mem_viol, sfr_viol, irq, ok, bad;
    logic [1:0] cpu_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, seg_ptr;
    logic [7:0] seg_en;
    logic [127:0] hwu;
    int err_total, n_compared;
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    mbac_top u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cpu_mode_i(cpu_mode), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_req_i(mem_req),
        .mem_addr_i(mem_addr), .mem_write_i(mem_write), .mem_ack_o(mem_ack),
        .mem_grant_o(mem_grant), .mem_viol_o(mem_viol), .sfr_viol_o(sfr_viol), .irq_o(irq),
        .seg_table_ptr_o(seg_ptr), .seg_enable_o(seg_en), .hwu_ctrl_o(hwu));
    mbac_core_model u_core (.mclk_i(mclk_i), .mem_ack_i(mem_ack), .mem_grant_i(mem_grant),
        .mem_viol_i(mem_viol), .cpu_mode_o(cpu_mode), .mem_req_o(mem_req),
        .mem_addr_o(mem_addr), .mem_write_o(mem_write));
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // one apb transfer; checks read data and error response
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd,
        input logic [31:0] x, input logic xe);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a hang
        do begin
            @(posedge mclk_i);
        end while (pready !== 1'b1);
        chk_word(prdata, x);
        chk_bit(pslverr, xe);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mem(input logic [31:0] a, input logic w, input logic g);
        u_core.access(a, w, ok, bad);
        chk_bit(ok, g);
        chk_bit(bad, !g);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // run needs about 170 cycles; allow 5000
    initial begin
        #50000;
        err_total++;
        end_of_test();
    end
    initial begin
        rstn_i = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        err_total = 0;
        n_compared = 0;
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        acc(1'b0, `MBAC_OFS_SEG_PTR, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_SEG_EN, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_SEG_WR, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_USR_GRANT, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_HWU_BASE, 0, 0, 1'b0);
        acc(1'b1, `MBAC_OFS_PART_BOUND, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_PART_BOUND, 0, `MBAC_PART_BOUND, 1'b0);
        mem(32'h0000_1000, 1'b0, 1'b0);
        mem(32'h0002_0000, 1'b1, 1'b1);
        u_core.set_mode(2'h1);
        mem(32'h0002_0000, 1'b0, 1'b0);
        mem(32'h0000_1000, 1'b0, 1'b0);
        acc(1'b1, `MBAC_OFS_SEG_PTR, 32'hA5A5_0000, 0, 1'b1);
        acc(1'b1, `MBAC_OFS_SEG_EN, 32'hFF, 0, 1'b1);
        acc(1'b0, `MBAC_OFS_SEG_EN, 0, 0, 1'b1);
        acc(1'b0, `MBAC_OFS_CPU_STAT, 0, 32'h1, 1'b0);
        acc(1'b0, `MBAC_OFS_HWU_BASE + 12'h008, 0, 0, 1'b1);
        u_core.set_mode(2'h2);
        mem(32'h0000_1000, 1'b1, 1'b1);
        acc(1'b0, `MBAC_OFS_CPU_STAT, 0, 32'h2, 1'b0);
        acc(1'b0, `MBAC_OFS_HWU_BASE + 12'h008, 0, 0, 1'b1);
        u_core.set_mode(2'h0);
        acc(1'b0, `MBAC_OFS_SEG_PTR, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_VIOL_ADDR, 0, 32'h48, 1'b0);
        acc(1'b1, `MBAC_OFS_SEG_PTR, 32'h1234_5678, 0, 1'b0);
        @(negedge mclk_i);
        chk_word(seg_ptr, 32'h1234_5678);
        acc(1'b1, `MBAC_OFS_SEG_EN, 32'h04, 0, 1'b0);
        acc(1'b1, `MBAC_OFS_USR_GRANT, 32'h4, 0, 1'b0);
        acc(1'b1, `MBAC_OFS_VND_GRANT, 32'h1, 0, 1'b0);
        acc(1'b1, `MBAC_OFS_HWU_BASE, 32'hCAFE_0001, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_HWU_BASE, 0, 32'hCAFE_0001, 1'b0);
        u_core.set_mode(2'h1);
        mem(32'h0002_0000, 1'b0, 1'b1);
        mem(32'h0002_0000, 1'b1, 1'b0);
        mem(32'h0003_0000, 1'b0, 1'b0);
        acc(1'b1, `MBAC_OFS_HWU_BASE + 12'h008, 32'hA5, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_HWU_BASE + 12'h008, 0, 32'hA5, 1'b0);
        acc(1'b0, `MBAC_OFS_HWU_BASE + 12'h004, 0, 0, 1'b1);
        u_core.set_mode(2'h2);
        acc(1'b0, `MBAC_OFS_HWU_BASE, 0, 32'hCAFE_0001, 1'b0);
        mem(32'h0002_0000, 1'b0, 1'b1);
        mem(32'h0002_0000, 1'b1, 1'b0);
        u_core.set_mode(2'h3);
        mem(32'h0002_0000, 1'b0, 1'b0);
        acc(1'b0, `MBAC_OFS_CPU_STAT, 0, 0, 1'b1);
        u_core.set_mode(2'h0);
        @(negedge mclk_i);
        chk_word(hwu[95:64], 32'hA5);
        chk_word({24'h0, seg_en}, 32'h04);
        acc(1'b0, 12'h100, 0, 0, 1'b1);
        @(negedge mclk_i);
        chk_bit(sfr_viol, 1'b1);
        acc(1'b0, `MBAC_OFS_INT_STAT, 0, 32'h3, 1'b0);
        chk_bit(irq, 1'b0);
        acc(1'b1, `MBAC_OFS_INT_MASK, 32'h2, 0, 1'b0);
        repeat (2) @(negedge mclk_i);
        chk_bit(irq, 1'b1);
        acc(1'b1, `MBAC_OFS_INT_STAT, 32'h3, 0, 1'b0);
        repeat (2) @(negedge mclk_i);
        chk_bit(irq, 1'b0);
        acc(1'b0, `MBAC_OFS_INT_STAT, 0, 0, 1'b0);
        // second reset in mid-run: configured attributes must fall back
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        chk_word({24'h0, seg_en}, 32'h00);
        acc(1'b0, `MBAC_OFS_SEG_PTR, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_USR_GRANT, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_INT_MASK, 0, 0, 1'b0);
        acc(1'b0, `MBAC_OFS_HWU_BASE, 0, 0, 1'b0);
        end_of_test();
    end
endmodule // tb
